// File: logic/nvb_pkg.sv
// Purpose: Constants for the bulk nonvolatile access block
// Assumes: Command-level register access from the device's bus engine
// Notes: Contract
package nvb_pkg;
  localparam logic [7:0]  KEY_FIRST      = 8'h2b;
  localparam logic [7:0]  KEY_USER_OPT   = 8'hd4;
  localparam logic [7:0]  KEY_USER_REQ   = 8'hd5;
  localparam logic [7:0]  KEY_READ_MID   = 8'h91;
  localparam logic [7:0]  KEY_READ_OPT   = 8'he4;
  localparam logic [7:0]  KEY_READ_REQ   = 8'he5;
  localparam logic [7:0]  ERASE_KEY      = 8'h2b;
  localparam int          WORD_AW        = 8;
  localparam logic [15:0] USER_WORDS     = 16'h0100;
  localparam logic [15:0] LAYOUT_REV_ID  = 16'h0001; // Arbitrary value
  localparam logic [15:0] ERASED_WORD    = 16'hffff;
  localparam int          CLK_MHZ        = 25;
  localparam int          PROG_TIME_US   = 170;
  localparam int          ERASE_TIME_MS  = 400;
  localparam int          PROG_CYCLES    = PROG_TIME_US * CLK_MHZ;
  localparam int          ERASE_CYCLES   = ERASE_TIME_MS * 1000 * CLK_MHZ;
  localparam logic [7:0]  RESET_KEY      = 8'h00;
  localparam logic [15:0] RESET_PTR      = 16'h0000;
  localparam int          BUSY_BIT       = 6;
  localparam logic [7:0]  STATUS_IDLE    = 8'hff;
  typedef enum logic [4:0] {
    NVB_LOCKED = 5'b00001,
    NVB_KEY1   = 5'b00010,
    NVB_KEY2R  = 5'b00100,
    NVB_UNL_RW = 5'b01000,
    NVB_UNL_RO = 5'b10000
  } nvb_lock_e;
  typedef enum logic [1:0] {
    NVB_CMD_NONE = 2'h0,
    NVB_CMD_RD   = 2'h1,
    NVB_CMD_WR   = 2'h2
  } nvb_dir_e;
endpackage : nvb_pkg

// File: logic/nvb_bulk_access.sv
// Purpose: Key-protected bulk erase, program and readback of user nonvolatile words
// Assumes: Bus engine presents decoded commands as one-cycle strobes on ref_clk_i
// Notes: Storage is modelled by an internal array; volatile configuration is not touched
`timescale 1ns/1ps
module nvb_bulk_access
  import nvb_pkg::*;
#(
  parameter int ERASE_CNT = ERASE_CYCLES,
  parameter int PROG_CNT  = PROG_CYCLES
) (
  input  wire logic        ref_clk_i,
  input  wire logic        reset_n_i,
  input  wire logic        unlock_wr_i,
  input  wire logic        unlock_rd_i,
  input  wire logic        erase_wr_i,
  input  wire logic        erase_rd_i,
  input  wire logic        data_wr_i,
  input  wire logic        data_rd_i,
  input  wire logic        status_rd_i,
  input  wire logic        other_cmd_i,
  input  wire logic        pec_ok_i,
  input  wire logic [15:0] wdata_i,
  output logic      [15:0] rdata_o,
  output logic             rvalid_o,
  output logic             ack_o,
  output logic             nack_o,
  output logic             alert_line_n_o,
  output logic             pec_required_o,
  output logic             busy_n_o
);

  nvb_lock_e      lock_q;
  logic [7:0]     unlock_key_q;
  logic [7:0]     erase_key_q;
  logic [15:0]    ptr_q;
  logic           erased_q;
  logic           pec_req_q;
  logic [31:0]    busy_cnt_q;
  logic           busy_q;
  logic [15:0]    mem_q [0:(1<<WORD_AW)-1];

  logic any_cmd;
  logic bulk_cmd;
  logic pec_bad;
  logic wr_reject;
  assign any_cmd  = unlock_wr_i | unlock_rd_i | erase_wr_i | erase_rd_i | data_wr_i | data_rd_i | other_cmd_i;
  // A word write that cannot be stored is refused on the bus as well as locking
  assign wr_reject = data_wr_i && (lock_q != NVB_UNL_RW || !erased_q || ptr_q >= USER_WORDS);
  assign bulk_cmd = erase_wr_i | data_wr_i | data_rd_i;
  // Required checksum missing makes the bulk command void
  assign pec_bad  = pec_req_q & ~pec_ok_i;

  function automatic logic is_unl(input nvb_lock_e s);
    is_unl = (s == NVB_UNL_RW) || (s == NVB_UNL_RO);
  endfunction : is_unl

  // Busy timer: erase or word program occupies the memory
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      busy_cnt_q <= 32'h0;
      busy_q     <= 1'b0;
    end else if (!busy_q && !pec_bad && erase_wr_i && lock_q == NVB_UNL_RW && wdata_i[7:0] == ERASE_KEY) begin
      busy_cnt_q <= ERASE_CNT[31:0];
      busy_q     <= 1'b1;
    end else if (!busy_q && !pec_bad && data_wr_i && lock_q == NVB_UNL_RW && erased_q
                 && ptr_q < USER_WORDS) begin
      busy_cnt_q <= PROG_CNT[31:0];
      busy_q     <= 1'b1;
    end else if (busy_q) begin
      busy_cnt_q <= busy_cnt_q - 32'h1;
      busy_q     <= (busy_cnt_q > 32'h1);
    end
  end

  // Lock sequencer
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      lock_q       <= NVB_LOCKED;
      unlock_key_q <= RESET_KEY;
      pec_req_q    <= 1'b0;
      ptr_q        <= RESET_PTR;
    end else if (!busy_q) begin
      if (unlock_wr_i) begin
        unlock_key_q <= wdata_i[7:0];
        case (lock_q)
          NVB_KEY1: begin
            if (wdata_i[7:0] == KEY_USER_OPT || wdata_i[7:0] == KEY_USER_REQ) begin
              lock_q    <= NVB_UNL_RW;
              pec_req_q <= (wdata_i[7:0] == KEY_USER_REQ);
              ptr_q     <= RESET_PTR;
            end else if (wdata_i[7:0] == KEY_READ_MID) begin
              lock_q <= NVB_KEY2R;
            end else begin
              lock_q <= NVB_LOCKED;
            end
          end
          NVB_KEY2R: begin
            if (wdata_i[7:0] == KEY_READ_OPT || wdata_i[7:0] == KEY_READ_REQ) begin
              lock_q    <= NVB_UNL_RO;
              pec_req_q <= (wdata_i[7:0] == KEY_READ_REQ);
              ptr_q     <= RESET_PTR;
            end else begin
              lock_q <= NVB_LOCKED;
            end
          end
          default: begin
            // A fresh first key restarts the sequence from the locked or an unlocked state; in NVB_KEY1 or NVB_KEY2R it locks instead
            lock_q <= (wdata_i[7:0] == KEY_FIRST) ? NVB_KEY1 : NVB_LOCKED;
          end
        endcase
      end else if (!pec_bad && erase_wr_i) begin
        if (lock_q != NVB_UNL_RW || wdata_i[7:0] != ERASE_KEY) begin
          lock_q <= NVB_LOCKED;
        end
      end else if (!pec_bad && data_rd_i) begin
        if (!is_unl(lock_q) || ptr_q >= USER_WORDS + 16'h2) begin
          lock_q <= NVB_LOCKED;
        end else begin
          ptr_q <= ptr_q + 16'h1;
        end
      end else if (!pec_bad && data_wr_i) begin
        if (lock_q != NVB_UNL_RW || !erased_q || ptr_q >= USER_WORDS) begin
          lock_q <= NVB_LOCKED;
        end else begin
          ptr_q <= ptr_q + 16'h1;
        end
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      erase_key_q <= RESET_KEY;
      erased_q    <= 1'b0;
    end else if (!busy_q && erase_wr_i && !pec_bad) begin
      erase_key_q <= wdata_i[7:0];
      erased_q    <= (lock_q == NVB_UNL_RW) && (wdata_i[7:0] == ERASE_KEY);
    end else if (!busy_q && unlock_wr_i && wdata_i[7:0] == KEY_FIRST) begin
      erased_q <= 1'b0;
    end
  end

  // Nonvolatile array only; no path reaches working configuration
  always_ff @(posedge ref_clk_i) begin
    if (!busy_q && !pec_bad && erase_wr_i && lock_q == NVB_UNL_RW && wdata_i[7:0] == ERASE_KEY) begin
      for (int i = 0; i < (1 << WORD_AW); i++) begin
        mem_q[i] <= ERASED_WORD;
      end
    end else if (!busy_q && !pec_bad && data_wr_i && lock_q == NVB_UNL_RW && erased_q && ptr_q < USER_WORDS) begin
      mem_q[ptr_q[WORD_AW-1:0]] <= wdata_i;
    end
  end

  // Read data and answers
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      rdata_o  <= 16'h0;
      rvalid_o <= 1'b0;
    end else begin
      rvalid_o <= 1'b0;
      if (status_rd_i) begin
        rdata_o  <= {8'h0, STATUS_IDLE & ~(8'(busy_q) << BUSY_BIT)};
        rvalid_o <= 1'b1;
      end else if (!busy_q && unlock_rd_i) begin
        rdata_o  <= is_unl(lock_q) ? {8'h0, unlock_key_q} : 16'h0;
        rvalid_o <= 1'b1;
      end else if (!busy_q && erase_rd_i) begin
        rdata_o  <= {8'h0, erase_key_q};
        rvalid_o <= 1'b1;
      end else if (!busy_q && data_rd_i && !pec_bad) begin
        rvalid_o <= 1'b1;
        if (!is_unl(lock_q) || ptr_q >= USER_WORDS + 16'h2) begin
          rdata_o <= 16'h0;
        end else if (ptr_q == 16'h0) begin
          rdata_o <= LAYOUT_REV_ID;
        end else if (ptr_q == 16'h1) begin
          rdata_o <= USER_WORDS;
        end else begin
          rdata_o <= mem_q[WORD_AW'(ptr_q - 16'h2)];
        end
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      ack_o          <= 1'b0;
      nack_o         <= 1'b0;
      alert_line_n_o <= 1'b1;
      busy_n_o       <= 1'b1;
      pec_required_o <= 1'b0;
    end else begin
      ack_o          <= status_rd_i | (!busy_q && any_cmd && !(bulk_cmd && pec_bad) && !wr_reject);
      nack_o         <= !status_rd_i && ((busy_q && any_cmd) || (bulk_cmd && pec_bad) || wr_reject);
      // Alert held low from a command refused while busy until the memory is idle again
      alert_line_n_o <= (busy_q && any_cmd && !status_rd_i) ? 1'b0 : (busy_q ? alert_line_n_o : 1'b1);
      busy_n_o       <= ~busy_q;
      pec_required_o <= pec_req_q;
    end
  end

endmodule : nvb_bulk_access

// File: bench/nvb_monitor.sv
// Purpose: Port checker for nvb_bulk_access
// Assumes: Command strobes are single-cycle pulses
// Notes: Busy length is bounded by the erase count handed down
`timescale 1ns/1ps
module nvb_monitor
  import nvb_pkg::*;
#(parameter int ERASE_CNT = ERASE_CYCLES, parameter int PROG_CNT = PROG_CYCLES) (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic unlock_wr_i,
  input wire logic unlock_rd_i,
  input wire logic erase_wr_i,
  input wire logic erase_rd_i,
  input wire logic data_wr_i,
  input wire logic data_rd_i,
  input wire logic status_rd_i,
  input wire logic other_cmd_i,
  input wire logic ack_o,
  input wire logic nack_o,
  input wire logic alert_line_n_o,
  input wire logic busy_n_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  logic        cmd;
  logic        wr;
  logic [31:0] low_q;
  assign cmd = unlock_wr_i | unlock_rd_i | erase_wr_i | erase_rd_i | data_wr_i | data_rd_i | other_cmd_i;
  assign wr = erase_wr_i | data_wr_i;
  // Counts cycles spent busy so a stuck busy flag is caught
  always_ff @(posedge ref_clk_i) low_q <= (!reset_n_i || busy_n_o) ? '0 : low_q + 1;
  a_status_ack: assert property (status_rd_i |=> ack_o && !nack_o) else $error("status read refused");
  a_busy_nack: assert property (cmd && !busy_n_o ##1 !busy_n_o |-> nack_o && !ack_o) else $error("busy no nack");
  a_busy_alert: assert property (cmd && !busy_n_o ##1 !busy_n_o |-> !alert_line_n_o) else $error("no alert");
  a_answer_once: assert property (!(ack_o && nack_o)) else $error("ack and nack together");
  a_answer_cause: assert property ((ack_o || nack_o) |-> $past(cmd) || $past(status_rd_i)) else $error("stray answer");
  a_busy_start: assert property ($fell(busy_n_o) |-> $past(wr) || $past(wr, 2) || $past(wr, 3)) else $error("stray busy");
  a_prog_busy: assert property (data_wr_i ##1 ack_o |-> ##[1:3] !busy_n_o) else $error("program not busy");
  a_busy_bound: assert property (low_q <= ERASE_CNT + 4) else $error("busy too long");
endmodule : nvb_monitor
bind nvb_bulk_access nvb_monitor #(.ERASE_CNT(ERASE_CNT), .PROG_CNT(PROG_CNT)) u_nvb_monitor (.ref_clk_i, .reset_n_i,
  .unlock_wr_i, .unlock_rd_i, .erase_wr_i, .erase_rd_i, .data_wr_i, .data_rd_i, .status_rd_i, .other_cmd_i,
  .ack_o, .nack_o, .alert_line_n_o, .busy_n_o);

// File: bench/nvb_host_model.sv
// Purpose: Host side issuing one command at a time
// Assumes: Answer arrives one cycle after the strobe edge
// Notes: Released write data is inverted so stale data never looks valid
`timescale 1ns/1ps
module nvb_host_model (
  input  wire logic        ref_clk_i,
  input  wire logic        busy_n_i,
  input  wire logic [15:0] rdata_i,
  input  wire logic        rvalid_i,
  input  wire logic        ack_i,
  input  wire logic        nack_i,
  output logic      [7:0]  stb_o,
  output logic             pec_ok_o,
  output logic      [15:0] wdata_o
);
  initial begin
    stb_o = '0;
    pec_ok_o = 1'b1;
    wdata_o = '0;
  end
  // Read sessions only read; write sessions may also read
  task automatic cmd(input int k, input logic [15:0] d, output logic [15:0] rd, output logic [2:0] rsp);
    @(posedge ref_clk_i);
    #1 stb_o = 8'h01 << k;
    wdata_o = d;
    @(posedge ref_clk_i);
    #1 stb_o = '0;
    wdata_o = ~d;
    rd = rdata_i;
    rsp = {rvalid_i, ack_i, nack_i};
  endtask : cmd
  task automatic wait_idle(output logic ok);
    logic [15:0] rd;
    logic [2:0]  rsp;
    ok = 1'b0;
    for (int i = 0; i < 100 && !ok; i++) begin
      cmd(6, 16'h0000, rd, rsp);
      ok = busy_n_i;
    end
  endtask : wait_idle
endmodule : nvb_host_model

// File: bench/tb_nvb_bulk_access.sv
// Purpose: Self-checking bench for nvb_bulk_access
// Assumes: Shortened erase and program counts
// Notes: Programmed words are random from a fixed seed
`timescale 1ns/1ps
module tb_nvb_bulk_access;
  import nvb_pkg::*;
  localparam int EC = 20;
  localparam int PC = 5;
  logic        ref_clk_i, reset_n_i, pec, rvalid, ack, nack, alert_n, pec_req, busy_n, ok;
  logic [7:0]  stb;
  logic [15:0] wd, rdata, rd, mem [256];
  logic [2:0]  rsp;
  logic [7:0]  rmode [2] = '{KEY_READ_OPT, KEY_READ_REQ};
  int          error_cnt, comparisons, seed, cyc;
  nvb_bulk_access #(.ERASE_CNT(EC), .PROG_CNT(PC)) u_nvb_bulk_access (.ref_clk_i, .reset_n_i,
    .unlock_wr_i(stb[0]), .unlock_rd_i(stb[1]), .erase_wr_i(stb[2]), .erase_rd_i(stb[3]), .data_wr_i(stb[4]),
    .data_rd_i(stb[5]), .status_rd_i(stb[6]), .other_cmd_i(stb[7]), .pec_ok_i(pec), .wdata_i(wd), .rdata_o(rdata),
    .rvalid_o(rvalid), .ack_o(ack), .nack_o(nack), .alert_line_n_o(alert_n), .pec_required_o(pec_req), .busy_n_o(busy_n));
  nvb_host_model u_nvb_host_model (.ref_clk_i, .busy_n_i(busy_n), .rdata_i(rdata), .rvalid_i(rvalid),
    .ack_i(ack), .nack_i(nack), .stb_o(stb), .pec_ok_o(pec), .wdata_o(wd));
  task automatic check(input string nm, input logic [15:0] e, input logic [15:0] s);
    comparisons++;
    if (s !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask : check
  task automatic c(input int k, input logic [15:0] d);
    u_nvb_host_model.cmd(k, d, rd, rsp);
  endtask : c
  task automatic conclude;
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : conclude
  initial begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc > 20000) begin
      error_cnt++;
      conclude();
    end
  end
  initial begin
    seed = 40;
    reset_n_i = 1'b0;
    repeat (10) @(posedge ref_clk_i);
    #1 reset_n_i = 1'b1;
    check("busy_n", 1, busy_n);
    c(0, KEY_FIRST);
    c(0, KEY_USER_REQ);
    @(posedge ref_clk_i);
    #1 check("pec_req", 1, pec_req);
    c(1, 0);
    check("unlock_rd", KEY_USER_REQ, rd[7:0]);
    u_nvb_host_model.pec_ok_o = 1'b0;
    c(2, ERASE_KEY);
    check("bad pec", 1, rsp[1:0]);
    u_nvb_host_model.pec_ok_o = 1'b1;
    c(2, ERASE_KEY);
    c(6, 0);
    check("status ack", 2, rsp[1:0]);
    check("erase busy", 0, busy_n);
    c(7, 0);
    check("busy cmd", 1, rsp[1:0]);
    check("alert", 0, alert_n);
    u_nvb_host_model.wait_idle(ok);
    check("erase idle", 1, ok);
    for (int i = 0; i < 256; i++) begin
      mem[i] = 16'($random(seed));
      c(4, mem[i]);
      check("wr ack", 2, rsp[1:0]);
      u_nvb_host_model.wait_idle(ok);
    end
    c(4, 16'h1234);
    check("extra wr", 1, rsp[1:0]);
    c(1, 0);
    check("locked key", 0, rd);
    for (int m = 0; m < 2; m++) begin
      c(0, KEY_FIRST);
      c(0, KEY_READ_MID);
      c(0, rmode[m]);
      @(posedge ref_clk_i);
      #1 check("pec_req", m, pec_req);
      c(5, 0);
      check("rev id", LAYOUT_REV_ID, rd);
      c(5, 0);
      check("count", USER_WORDS, rd);
      for (int i = 0; i < 256; i++) begin
        u_nvb_host_model.pec_ok_o = (m == 1) | 1'($random(seed));
        c(5, 0);
        check("word", mem[i], rd);
      end
      c(5, 0);
      check("extra rd", 0, rd);
      c(1, 0);
      check("locked", 0, rd);
    end
    c(0, KEY_FIRST);
    c(0, KEY_USER_OPT);
    @(posedge ref_clk_i);
    #1 check("pec_req", 0, pec_req);
    c(2, 16'h0055);
    c(3, 0);
    check("erase_rd", 8'h55, rd[7:0]);
    check("no erase", 1, busy_n);
    c(1, 0);
    check("bad erase", 0, rd);
    c(0, KEY_FIRST);
    c(0, 16'h0077);
    c(1, 0);
    check("bad key", 0, rd);
    conclude();
  end
endmodule : tb_nvb_bulk_access
